/* File: design/pfs_pkg.sv */
// Constants and types for the pilot tone sensing block.
// Assumes a 50 MHz system clock and a 21.52 MHz real low-IF sample stream.
package pfs_pkg;
  // Input rate, pilot offset and decimated rate, all in hertz.
  localparam longint IN_RATE_HZ  = 21520000;
  localparam longint PILOT_HZ    = 2690000;
  localparam longint OUT_RATE_HZ = 53800;
  // Mixer phase steps per pilot cycle and decimation factor.
  localparam int MIX_STEPS = int'(IN_RATE_HZ / PILOT_HZ);
  localparam int DEC_FACT  = int'(IN_RATE_HZ / OUT_RATE_HZ);
  localparam int PH_W      = $clog2(MIX_STEPS);
  localparam int DEC_W     = $clog2(DEC_FACT);
  localparam logic [DEC_W-1:0] DEC_LAST = DEC_W'(DEC_FACT - 1);
  // Data widths.
  localparam int SAMP_W  = 12;
  localparam int TW_W    = 16;
  localparam int FRAC    = 15;
  localparam int X_W     = 16;
  localparam int INT_W   = SAMP_W + 1 + DEC_W + 1;
  localparam int ACC_W   = 26;
  localparam int PWR_W   = 2 * ACC_W + 1;
  localparam int SUM_W   = PWR_W + 4;
  localparam int BIN_W   = 9;
  localparam int NMAX    = 512;
  localparam int DL_W    = 3;
  localparam int DW_W    = 4;
  localparam int CNT_W   = 5;
  // Q1.15 twiddle constants; rotation by one bin is cos - j*sin.
  localparam logic signed [TW_W-1:0] Q_ONE  = 16'sh7FFF;
  localparam logic signed [TW_W-1:0] Q_HALF = 16'sh5A82;
  localparam logic signed [TW_W-1:0] W32_C  = 16'sh7D8A;
  localparam logic signed [TW_W-1:0] W32_S  = 16'sh18F9;
  localparam logic signed [TW_W-1:0] W256_C = 16'sh7FF6;
  localparam logic signed [TW_W-1:0] W256_S = 16'sh0324;
  localparam logic signed [TW_W-1:0] W512_C = 16'sh7FFD;
  localparam logic signed [TW_W-1:0] W512_S = 16'sh0192;
  // Last bin index for each transform length.
  localparam logic [BIN_W-1:0] LAST_32  = 9'h01F;
  localparam logic [BIN_W-1:0] LAST_256 = 9'h0FF;
  localparam logic [BIN_W-1:0] LAST_512 = 9'h1FF;
  // Sensing window duration selects the transform length.
  typedef enum logic [1:0] {
    PFS_WIN_1MS = 2'h0, PFS_WIN_5MS = 2'h1, PFS_WIN_10MS = 2'h2
  } pfs_win_t;
  // Detection method.
  typedef enum logic [1:0] {
    PFS_SINGLE = 2'h0, PFS_HARD = 2'h1, PFS_SOFT = 2'h2, PFS_LOC = 2'h3
  } pfs_mode_t;
  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_CLEAR = 5'h02, ST_COLLECT = 5'h04,
    ST_BINS = 5'h08, ST_POWER = 5'h10
  } pfs_state_t;
endpackage

/* File: design/pfs_sense.sv */
// Pilot tone sensing: mixer, boxcar filter and decimator, serial DFT,
// power accumulation, peak search and detection decision.
// Assumes ADC data and strobe come from another clock domain; the
// control inputs come from the sensing controller on clk.
// Behaviour
// - Real low-IF input, fixed pilot offset.
// - Mix down by complex pilot-offset exponential.
// - Low-pass filter near forty kilohertz total.
// - Decimate input rate down to reduced rate.
// - Window duration selects 32, 256 or 512 points.
// - Report peak squared magnitude and its bin.
// - Ten millisecond window may use 512 points.
// - Average squared outputs bin-wise across dwells.
// - Single window detects when peak exceeds threshold.
// - Hard decisions counted against configured count.
// - Soft combining compares averaged peak with threshold.
// - Location mode compares half peak bins.
// - Thresholds set from false alarm and size.
`timescale 1ns/1ps
module pfs_sense (
  input  wire logic                         clk,
  input  wire logic                         rst_b,
  input  wire logic [pfs_pkg::SAMP_W-1:0]   adc_data,
  input  wire logic                         adc_strobe,
  input  wire logic                         start,
  input  wire pfs_pkg::pfs_win_t            win_sel,
  input  wire pfs_pkg::pfs_mode_t           mode,
  input  wire logic [pfs_pkg::DL_W-1:0]     dwell_log2,
  input  wire logic                         dwell_en,
  input  wire logic [pfs_pkg::SUM_W-1:0]    energy_thr,
  input  wire logic [pfs_pkg::CNT_W-1:0]    count_thr,
  input  wire logic [pfs_pkg::BIN_W-1:0]    loc_thr,
  output logic                              busy,
  output logic                              det_valid,
  output logic                              detect,
  output logic [pfs_pkg::SUM_W-1:0]         peak_val,
  output logic [pfs_pkg::BIN_W-1:0]         peak_bin
);
  import pfs_pkg::*;

  // Mixer lookup: cos(2*pi*i/8); -sin uses index i+2.
  function automatic logic signed [TW_W-1:0] cos8(input logic [PH_W-1:0] i);
    case (i)
      3'h0:      cos8 = Q_ONE;
      3'h1, 3'h7: cos8 = Q_HALF;
      3'h2, 3'h6: cos8 = '0;
      3'h3, 3'h5: cos8 = -Q_HALF;
      default:   cos8 = -Q_ONE;
    endcase
  endfunction

  // Q1.15 complex product, packed as {re, im}.
  function automatic logic [2*TW_W-1:0] cmul(
    input logic signed [TW_W-1:0] ar, ai, br, bi);
    logic signed [2*TW_W:0] r;
    logic signed [2*TW_W:0] m;
    r = (2*TW_W+1)'(ar * br) - (2*TW_W+1)'(ai * bi);
    m = (2*TW_W+1)'(ar * bi) + (2*TW_W+1)'(ai * br);
    cmul = {TW_W'(r >>> FRAC), TW_W'(m >>> FRAC)};
  endfunction

  // Two-stage synchronisers for the ADC pins, plus an edge history flop.
  logic [SAMP_W-1:0] dat_s1, dat_s2;
  logic              str_s1, str_s2, str_s3;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dat_s1 <= '0;
      dat_s2 <= '0;
      str_s1 <= 1'b0;
      str_s2 <= 1'b0;
      str_s3 <= 1'b0;
    end else begin
      dat_s1 <= adc_data;
      dat_s2 <= dat_s1;
      str_s1 <= adc_strobe;
      str_s2 <= str_s1;
      str_s3 <= str_s2;
    end
  end

  // Front end state: mixer phase, boxcar integrators, decimated output.
  logic                    samp_ev;
  logic [PH_W-1:0]         ph_r, ph_nxt;
  logic [DEC_W-1:0]        dcnt_r, dcnt_nxt;
  logic signed [INT_W-1:0] ire_r, ire_nxt, iim_r, iim_nxt;
  logic signed [X_W-1:0]   xre_r, xre_nxt, xim_r, xim_nxt;
  logic                    dvld_r, dvld_nxt;
  logic signed [SAMP_W+TW_W-1:0] mre, mim;
  logic signed [INT_W-1:0]       sre, sim;

  // One rising strobe edge is one real sample; the pilot sits at fs/8,
  // so the exponential is an exact eight-entry table.
  always_comb begin
    samp_ev  = str_s2 & ~str_s3;
    mre      = $signed(dat_s2) * cos8(ph_r);
    mim      = $signed(dat_s2) * cos8(ph_r + 3'h2);
    sre      = ire_r + INT_W'(mre >>> FRAC);
    sim      = iim_r + INT_W'(mim >>> FRAC);
    ph_nxt   = ph_r;
    dcnt_nxt = dcnt_r;
    ire_nxt  = ire_r;
    iim_nxt  = iim_r;
    xre_nxt  = xre_r;
    xim_nxt  = xim_r;
    dvld_nxt = 1'b0;
    if (samp_ev) begin
      ph_nxt = ph_r + 3'h1;
      // Integrate and dump over 400 samples: the sinc response is the
      // low-pass, wide enough for carrier offsets, and dumping decimates.
      if (dcnt_r == DEC_LAST) begin
        dcnt_nxt = '0;
        ire_nxt  = '0;
        iim_nxt  = '0;
        xre_nxt  = sre[INT_W-1 -: X_W];
        xim_nxt  = sim[INT_W-1 -: X_W];
        dvld_nxt = 1'b1;
      end else begin
        dcnt_nxt = dcnt_r + 1'b1;
        ire_nxt  = sre;
        iim_nxt  = sim;
      end
    end
  end

  // Front end registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_r   <= '0;
      dcnt_r <= '0;
      ire_r  <= '0;
      iim_r  <= '0;
      xre_r  <= '0;
      xim_r  <= '0;
      dvld_r <= 1'b0;
    end else begin
      ph_r   <= ph_nxt;
      dcnt_r <= dcnt_nxt;
      ire_r  <= ire_nxt;
      iim_r  <= iim_nxt;
      xre_r  <= xre_nxt;
      xim_r  <= xim_nxt;
      dvld_r <= dvld_nxt;
    end
  end

  // Bin accumulators and the power sums across dwells.
  logic signed [ACC_W-1:0] acc_re [NMAX];
  logic signed [ACC_W-1:0] acc_im [NMAX];
  logic [SUM_W-1:0]        psum [NMAX];

  // Sequencer state.
  pfs_state_t            st_r, st_nxt;
  pfs_mode_t             mode_r, mode_nxt;
  logic [BIN_W-1:0]      k_r, k_nxt, n_r, n_nxt, len_r, len_nxt;
  logic [DW_W-1:0]       dw_r, dw_nxt;
  logic [DL_W-1:0]       dl_r, dl_nxt;
  logic signed [TW_W-1:0] wc_r, wc_nxt, ws_r, ws_nxt;
  logic signed [TW_W-1:0] qr_r, qr_nxt, qi_r, qi_nxt;
  logic signed [TW_W-1:0] pr_r, pr_nxt, pi_r, pi_nxt;
  logic signed [X_W-1:0]  xsr_r, xsr_nxt, xsi_r, xsi_nxt;
  logic [SUM_W-1:0]      pk_r, pk_nxt;
  logic [BIN_W-1:0]      pb_r, pb_nxt, b1_r, b1_nxt, dist_r, dist_nxt;
  logic [CNT_W-1:0]      pos_r, pos_nxt;
  logic                  det_r, det_nxt, dv_r, dv_nxt;
  logic [SUM_W-1:0]      pv_r, pv_nxt;
  logic [BIN_W-1:0]      pbo_r, pbo_nxt;
  // Array write port, driven by the sequencer.
  logic                    wr_en;
  logic signed [ACC_W-1:0] wr_re, wr_im;
  logic [SUM_W-1:0]        wr_ps;
  // Working terms.
  logic signed [2*X_W:0]   tre, tim;
  logic [PWR_W-1:0]        pw;
  logic [SUM_W-1:0]        s_sum, pk_fin, avg_fin;
  logic [BIN_W-1:0]        bin_fin;
  logic [DW_W-1:0]         dw_last, half_last;
  logic [DL_W-1:0]         seg_log;
  logic                    seg_end, fin, hit;

  // Next-state logic for the whole sensing interval.
  always_comb begin
    tre = (2*X_W+1)'(xsr_r * pr_r) - (2*X_W+1)'(xsi_r * pi_r);
    tim = (2*X_W+1)'(xsr_r * pi_r) + (2*X_W+1)'(xsi_r * pr_r);
    pw  = PWR_W'(acc_re[k_r] * acc_re[k_r]) + PWR_W'(acc_im[k_r] * acc_im[k_r]);
    s_sum     = psum[k_r] + SUM_W'(pw);
    dw_last   = DW_W'((1 << dl_r) - 1);
    half_last = DW_W'((1 << (dl_r - 3'h1)) - 1);
    // Hard and single decide each dwell; soft over all; location per half.
    case (mode_r)
      PFS_SOFT: begin
        seg_end = (dw_r == dw_last);
        seg_log = dl_r;
      end
      PFS_LOC: begin
        seg_end = (dw_r == dw_last) || (dw_r == half_last);
        seg_log = dl_r - 3'h1;
      end
      default: begin
        seg_end = 1'b1;
        seg_log = '0;
      end
    endcase
    pk_fin  = (s_sum > pk_r) ? s_sum : pk_r;
    bin_fin = (s_sum > pk_r) ? k_r : pb_r;
    avg_fin = pk_fin >> seg_log;
    hit     = (avg_fin > energy_thr);
    fin     = (st_r == ST_POWER) && (k_r == len_r) && seg_end;
    // Enum state is copied on its own; packing it with vectors would need casts.
    st_nxt   = st_r;
    mode_nxt = mode_r;
    {k_nxt, n_nxt, len_nxt, dw_nxt, dl_nxt} = {k_r, n_r, len_r, dw_r, dl_r};
    {wc_nxt, ws_nxt, qr_nxt, qi_nxt, pr_nxt, pi_nxt} =
      {wc_r, ws_r, qr_r, qi_r, pr_r, pi_r};
    {xsr_nxt, xsi_nxt, pk_nxt, pb_nxt, b1_nxt, dist_nxt, pos_nxt} =
      {xsr_r, xsi_r, pk_r, pb_r, b1_r, dist_r, pos_r};
    {det_nxt, pv_nxt, pbo_nxt} = {det_r, pv_r, pbo_r};
    dv_nxt = 1'b0;
    wr_en  = 1'b0;
    wr_re  = '0;
    wr_im  = '0;
    wr_ps  = '0;
    case (st_r)
      ST_IDLE: begin
        if (start) begin
          st_nxt   = ST_CLEAR;
          mode_nxt = mode;
          k_nxt    = '0;
          // Single window uses one dwell; location needs at least two.
          if (mode == PFS_SINGLE) dl_nxt = '0;
          else if (mode == PFS_LOC && dwell_log2 == '0) dl_nxt = 3'h1;
          else dl_nxt = dwell_log2;
          // Window duration picks the transform length.
          case (win_sel)
            PFS_WIN_1MS:  {len_nxt, wc_nxt, ws_nxt} = {LAST_32, W32_C, W32_S};
            PFS_WIN_10MS: {len_nxt, wc_nxt, ws_nxt} = {LAST_512, W512_C, W512_S};
            default:      {len_nxt, wc_nxt, ws_nxt} = {LAST_256, W256_C, W256_S};
          endcase
        end
      end
      ST_CLEAR: begin
        // Arrays power up unknown, so a full sweep clears them first.
        wr_en = 1'b1;
        k_nxt = k_r + 1'b1;
        if (k_r == LAST_512) begin
          st_nxt = ST_COLLECT;
          {k_nxt, n_nxt, dw_nxt} = '0;
          {qr_nxt, qi_nxt} = {Q_ONE, 16'sh0000};
          {pk_nxt, pb_nxt, pos_nxt} = '0;
        end
      end
      ST_COLLECT: begin
        // Gaps in the dwell gate pause the dwell rather than end it.
        if (dvld_r && dwell_en) begin
          st_nxt = ST_BINS;
          {k_nxt, xsr_nxt, xsi_nxt} = {9'h000, xre_r, xim_r};
          {pr_nxt, pi_nxt} = {Q_ONE, 16'sh0000};
        end
      end
      ST_BINS: begin
        // Bin k gains x[n]*w^(kn); p walks w^(kn) by repeated rotation.
        wr_en = 1'b1;
        wr_re = acc_re[k_r] + ACC_W'(tre >>> FRAC);
        wr_im = acc_im[k_r] + ACC_W'(tim >>> FRAC);
        wr_ps = psum[k_r];
        {pr_nxt, pi_nxt} = cmul(pr_r, pi_r, qr_r, qi_r);
        k_nxt = k_r + 1'b1;
        if (k_r == len_r) begin
          {qr_nxt, qi_nxt} = cmul(qr_r, qi_r, wc_r, -ws_r);
          k_nxt  = '0;
          n_nxt  = n_r + 1'b1;
          st_nxt = (n_r == len_r) ? ST_POWER : ST_COLLECT;
        end
      end
      ST_POWER: begin
        // Power joins the dwell sum; bins are cleared for the next dwell.
        wr_en = 1'b1;
        wr_ps = seg_end ? '0 : s_sum;
        k_nxt = k_r + 1'b1;
        if (seg_end) {pk_nxt, pb_nxt} = {pk_fin, bin_fin};
        if (k_r == len_r) begin
          st_nxt = ST_COLLECT;
          {k_nxt, n_nxt, dw_nxt} = {9'h000, 9'h000, DW_W'(dw_r + 4'h1)};
          {qr_nxt, qi_nxt} = {Q_ONE, 16'sh0000};
          if (seg_end) begin
            {pk_nxt, pb_nxt} = '0;
            if (mode_r == PFS_HARD && hit) pos_nxt = pos_r + 1'b1;
            if (mode_r == PFS_LOC && dw_r != dw_last) b1_nxt = bin_fin;
          end
          if (fin && dw_r == dw_last) begin
            st_nxt   = ST_IDLE;
            dv_nxt   = 1'b1;
            pv_nxt   = avg_fin;
            pbo_nxt  = bin_fin;
            dist_nxt = (bin_fin > b1_r) ? bin_fin - b1_r : b1_r - bin_fin;
            case (mode_r)
              PFS_HARD: det_nxt = (pos_nxt > count_thr);
              PFS_LOC:  det_nxt = (dist_nxt < loc_thr);
              default:  det_nxt = hit;
            endcase
          end
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // Array writes; contents need no reset because of the clear sweep.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      acc_re[k_r] <= wr_re;
      acc_im[k_r] <= wr_im;
      psum[k_r]   <= wr_ps;
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r   <= ST_IDLE;
      mode_r <= PFS_SINGLE;
      {k_r, n_r, len_r, dw_r, dl_r} <= {9'h000, 9'h000, LAST_32, 4'h0, 3'h0};
      {wc_r, ws_r, qr_r, qi_r, pr_r, pi_r} <= '0;
      {xsr_r, xsi_r, pk_r, pb_r, b1_r, dist_r, pos_r} <= '0;
      {det_r, dv_r, pv_r, pbo_r} <= '0;
    end else begin
      st_r   <= st_nxt;
      mode_r <= mode_nxt;
      {k_r, n_r, len_r, dw_r, dl_r} <= {k_nxt, n_nxt, len_nxt, dw_nxt, dl_nxt};
      {wc_r, ws_r, qr_r, qi_r, pr_r, pi_r} <= {wc_nxt, ws_nxt, qr_nxt, qi_nxt,
        pr_nxt, pi_nxt};
      {xsr_r, xsi_r, pk_r, pb_r, b1_r, dist_r, pos_r} <= {xsr_nxt, xsi_nxt,
        pk_nxt, pb_nxt, b1_nxt, dist_nxt, pos_nxt};
      {det_r, dv_r, pv_r, pbo_r} <= {det_nxt, dv_nxt, pv_nxt, pbo_nxt};
    end
  end

  // Result outputs come straight from flops; busy is decoded from the state register.
  assign busy      = (st_r != ST_IDLE);
  assign det_valid = dv_r;
  assign detect    = det_r;
  assign peak_val  = pv_r;
  assign peak_bin  = pbo_r;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_final;
    fin && (dw_r == dw_last);
  endsequence
  sequence s_report;
    det_valid ##1 !det_valid;
  endsequence

  property p_mix;
    samp_ev |=> ph_r == PH_W'($past(ph_r) + 3'h1);
  endproperty
  a_mix: assert property (p_mix) else $error("mixer phase did not step");
  property p_decim;
    samp_ev && dcnt_r == DEC_LAST |=> dvld_r && dcnt_r == '0 ##1 !dvld_r;
  endproperty
  a_decim: assert property (p_decim) else $error("decimator dump wrong");
  property p_len;
    st_r == ST_IDLE && start && win_sel == PFS_WIN_1MS |=> len_r == LAST_32;
  endproperty
  a_len: assert property (p_len) else $error("transform length wrong");
  property p_peak;
    st_r == ST_POWER && seg_end && k_r != len_r && s_sum > pk_r |=> pk_r == $past(s_sum);
  endproperty
  a_peak: assert property (p_peak) else $error("peak not tracked");
  property p_single;
    s_final and mode_r == PFS_SINGLE |=> detect == ($past(avg_fin) > $past(energy_thr));
  endproperty
  a_single: assert property (p_single) else $error("single decision wrong");
  property p_hard;
    s_final and mode_r == PFS_HARD |=> detect == (pos_r > $past(count_thr));
  endproperty
  a_hard: assert property (p_hard) else $error("hard decision wrong");
  property p_soft;
    s_final and mode_r == PFS_SOFT |=> detect == ($past(avg_fin) > $past(energy_thr));
  endproperty
  a_soft: assert property (p_soft) else $error("soft decision wrong");
  property p_loc;
    s_final and mode_r == PFS_LOC |=> detect == (dist_r < $past(loc_thr));
  endproperty
  a_loc: assert property (p_loc) else $error("location decision wrong");
  property p_report;
    s_final |=> s_report;
  endproperty
  a_report: assert property (p_report) else $error("report pulse wrong");
  property p_clear;
    st_r == ST_POWER |=> acc_re[$past(k_r)] == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("bin not cleared");
endmodule // pfs_sense

/* File: tb/pfs_adc_model.sv */
// Behavioural model of the analogue front end and converter that feeds the sensing block.
// Assumes the bench gives clk and a run level; samples are strobed only while run is high.
`timescale 1ns/1ps
module pfs_adc_model (
  input  wire logic        clk,
  input  wire logic        run,
  output logic [11:0]      adc_data,
  output logic             adc_strobe
);
  // One period of a real tone at one eighth of the sample rate, the nominal pilot offset.
  logic [11:0] tone [0:7];
  // Phase index; three bits wrap at the end of each tone period.
  logic [2:0]  idx;

  // Table values are signed two's complement with an amplitude of 1000 counts.
  initial begin
    tone[0] = 12'h3E8;
    tone[1] = 12'h2C3;
    tone[2] = 12'h000;
    tone[3] = 12'hD3D;
    tone[4] = 12'hC18;
    tone[5] = 12'hD3D;
    tone[6] = 12'h000;
    tone[7] = 12'h2C3;
    idx        = 3'h0;
    adc_data   = 12'h000;
    adc_strobe = 1'b0;
  end

  // Strobe is two cycles low and two high; data moves only at the start of the low
  // phase, so it has settled long before the rising edge crosses the synchroniser.
  always begin
    @(posedge clk);
    if (run) begin
      adc_strobe <= 1'b0;
      adc_data   <= tone[idx];
      idx        <= idx + 3'h1;
      @(posedge clk);
      @(posedge clk);
      adc_strobe <= 1'b1;
      @(posedge clk);
    end else begin
      // Outside a capture the lines carry no valid data, so the level keeps toggling.
      adc_strobe <= 1'b0;
      adc_data   <= ~adc_data;
    end
  end
endmodule // pfs_adc_model

/* File: tb/tb_top.sv */
// Self-checking bench for the pilot tone sensing block with a pilot tone source.
// Assumes a 50 MHz clock; bench inputs are driven at the falling edge, the converter model's lines at the rising edge.
`timescale 1ns/1ps
`define CHK(name, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); \
    end \
  end
module tb_top;
  // Clock cycles per converter sample in the source model.
  localparam int SAMP_CLK = 4;
  // Shortest interval for one 32-point dwell of decimated samples.
  localparam int LAT_MIN  = 32 * pfs_pkg::DEC_FACT * SAMP_CLK;
  // Ceiling on the whole run; one interval takes a little over LAT_MIN.
  localparam int LIMIT    = 70000;

  logic                          clk;
  logic                          rst_b;
  logic                          run;
  logic [pfs_pkg::SAMP_W-1:0]    adc_data;
  logic                          adc_strobe;
  logic                          start;
  pfs_pkg::pfs_win_t             win_sel;
  pfs_pkg::pfs_mode_t            mode;
  logic [pfs_pkg::DL_W-1:0]      dwell_log2;
  logic                          dwell_en;
  logic [pfs_pkg::SUM_W-1:0]     energy_thr;
  logic [pfs_pkg::CNT_W-1:0]     count_thr;
  logic [pfs_pkg::BIN_W-1:0]     loc_thr;
  logic                          busy;
  logic                          det_valid;
  logic                          detect;
  logic [pfs_pkg::SUM_W-1:0]     peak_val;
  logic [pfs_pkg::BIN_W-1:0]     peak_bin;
  int                            n_mismatch;
  int                            checks_done;
  int                            cycles;

  pfs_adc_model u_adc (
    .clk        (clk),
    .run        (run),
    .adc_data   (adc_data),
    .adc_strobe (adc_strobe)
  );

  pfs_sense u_dut (
    .clk        (clk),
    .rst_b      (rst_b),
    .adc_data   (adc_data),
    .adc_strobe (adc_strobe),
    .start      (start),
    .win_sel    (win_sel),
    .mode       (mode),
    .dwell_log2 (dwell_log2),
    .dwell_en   (dwell_en),
    .energy_thr (energy_thr),
    .count_thr  (count_thr),
    .loc_thr    (loc_thr),
    .busy       (busy),
    .det_valid  (det_valid),
    .detect     (detect),
    .peak_val   (peak_val),
    .peak_bin   (peak_bin)
  );

  // Free-running 50 MHz clock.
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Outputs are cleared while reset is held, and busy stays low at the first edge after it.
  task automatic test_reset();
    repeat (10) @(negedge clk);
    `CHK("busy_in_reset", 1'b0, busy)
    `CHK("det_valid_in_reset", 1'b0, det_valid)
    `CHK("detect_in_reset", 1'b0, detect)
    `CHK("peak_val_in_reset", 57'h0, peak_val)
    `CHK("peak_bin_in_reset", 9'h000, peak_bin)
    rst_b = 1'b1;
    @(negedge clk);
    `CHK("busy_after_reset", 1'b0, busy)
    $display("test_reset finished");
  endtask

  // A pilot at the nominal offset must land in bin zero of a 32-point single window,
  // with one report; a second request made while busy must leave no trace.
  task automatic test_single_tone();
    int lat;
    run        = 1'b1;
    dwell_en   = 1'b1;
    energy_thr = 57'h1;
    @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    `CHK("busy_after_start", 1'b1, busy)
    // Request with other settings while busy; it must be ignored.
    mode    = pfs_pkg::PFS_HARD;
    win_sel = pfs_pkg::PFS_WIN_10MS;
    start   = 1'b1;
    repeat (3) @(negedge clk);
    start   = 1'b0;
    mode    = pfs_pkg::PFS_SINGLE;
    win_sel = pfs_pkg::PFS_WIN_1MS;
    lat     = 4;
    while (det_valid !== 1'b1 && lat < LIMIT) begin
      @(negedge clk);
      lat++;
    end
    `CHK("det_valid", 1'b1, det_valid)
    `CHK("interval_len", 1'b1, (lat >= LAT_MIN) && (lat < 2 * LAT_MIN))
    `CHK("dwell_len_decimated", 1'b1, lat >= LAT_MIN)
    `CHK("busy_at_report", 1'b0, busy)
    `CHK("detect", 1'b1, detect)
    `CHK("peak_above_thr", 1'b1, peak_val > energy_thr)
    `CHK("peak_bin", 9'h000, peak_bin)
    `CHK("peak_nonzero", 1'b1, peak_val !== 57'h0)
    @(negedge clk);
    `CHK("det_valid_one_cycle", 1'b0, det_valid)
    `CHK("detect_holds", 1'b1, detect)
    `CHK("peak_bin_holds", 9'h000, peak_bin)
    repeat (50) @(negedge clk);
    `CHK("idle_after_report", 1'b0, busy)
    `CHK("no_second_report", 1'b0, det_valid)
    $display("test_single_tone finished after %0d cycles", lat);
  endtask

  // Cuts a hang short; an expired limit counts as a mismatch.
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      $display("CHECK FAILED run_time expected below %0d seen %0d", LIMIT, cycles);
      test_done();
    end
  end

  // Main sequence; every input has a value at time zero.
  initial begin
    n_mismatch  = 0;
    checks_done = 0;
    cycles      = 0;
    rst_b       = 1'b0;
    run         = 1'b0;
    start       = 1'b0;
    win_sel     = pfs_pkg::PFS_WIN_1MS;
    mode        = pfs_pkg::PFS_SINGLE;
    dwell_log2  = 3'h0;
    dwell_en    = 1'b0;
    energy_thr  = 57'h0;
    count_thr   = 5'h00;
    loc_thr     = 9'h002;
    test_reset();
    test_single_tone();
    test_done();
  end
endmodule // tb_top
